/* File: design/scb_config_port.v */
// serial configuration port and register bank of the clock buffer
`include "scb_defines.vh"
module scb_config_port (
  input wire CLOCK,
  input wire SRST,
  input wire SCL_IN,
  input wire SDA_IN,
  output wire SDA_OUT,
  output wire SDA_OE,
  input wire [2:0] ADDRESS_SELECT_PIN,
  input wire [1:0] PLL_MODE_STRAP,
  input wire FIRST_OUTPUT_ENABLE_PIN,
  input wire SECOND_OUTPUT_ENABLE_PIN,
  output reg FIRST_OUTPUT_ACTIVE,
  output reg SECOND_OUTPUT_ACTIVE,
  output reg [1:0] DISABLE_STATE,
  output reg [1:0] PLL_MODE,
  output reg [1:0] AMPLITUDE,
  output reg FIRST_OUTPUT_EDGE_SPEED,
  output reg SECOND_OUTPUT_EDGE_SPEED,
  output reg FEEDBACK_EDGE_SPEED,
  output reg FREQ_SW_ENABLE,
  output reg [1:0] FREQUENCY_CODE
);
  // ==========================================
  // states
  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_ADDR = 6'b000010;
  localparam [5:0] ST_ACK = 6'b000100;
  localparam [5:0] ST_RXB = 6'b001000;
  localparam [5:0] ST_TXB = 6'b010000;
  localparam [5:0] ST_MACK = 6'b100000;
  // byte roles in a write
  localparam [1:0] PH_INDEX = 2'd0;
  localparam [1:0] PH_COUNT = 2'd1;
  localparam [1:0] PH_DATA = 2'd2;
  // ==========================================
  // pin synchronisers
  wire scl_s;
  wire sda_s;
  wire oe1_s;
  wire oe2_s;
  scb_sync u_scl (.CLOCK(CLOCK), .SRST(SRST), .d(SCL_IN), .q(scl_s));
  scb_sync u_sda (.CLOCK(CLOCK), .SRST(SRST), .d(SDA_IN), .q(sda_s));
  scb_sync u_oe1 (.CLOCK(CLOCK), .SRST(SRST), .d(FIRST_OUTPUT_ENABLE_PIN), .q(oe1_s));
  scb_sync u_oe2 (.CLOCK(CLOCK), .SRST(SRST), .d(SECOND_OUTPUT_ENABLE_PIN), .q(oe2_s));
  reg scl_d_reg;
  reg sda_d_reg;
  always @(posedge CLOCK) begin
    if (SRST) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;
  wire start_cond = scl_s & scl_d_reg & ~sda_s & sda_d_reg;
  wire stop_cond = scl_s & scl_d_reg & sda_s & ~sda_d_reg;
  // ==========================================
  // straps caught once after reset release
  // straps pass the same two flops as every other pin
  wire [2:0] addr_sel_s;
  wire [1:0] pll_strap_s;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_addr_sync
      scb_sync u_addr_sel (.CLOCK(CLOCK), .SRST(SRST), .d(ADDRESS_SELECT_PIN[g]), .q(addr_sel_s[g]));
    end
    for (g = 0; g < 2; g = g + 1) begin : g_strap_sync
      scb_sync u_pll_strap (.CLOCK(CLOCK), .SRST(SRST), .d(PLL_MODE_STRAP[g]), .q(pll_strap_s[g]));
    end
  endgenerate
  reg strap_done_reg;
  reg [1:0] strap_wait_reg;
  reg [2:0] addr_lo_reg;
  reg [1:0] pll_latched_reg;
  always @(posedge CLOCK) begin
    if (SRST) begin
      strap_done_reg <= 1'b0;
      strap_wait_reg <= 2'h0;
      addr_lo_reg <= 3'h0;
      pll_latched_reg <= 2'h0;
    end else if (!strap_done_reg) begin
      // wait until the synchronisers no longer show their reset level
      if (strap_wait_reg == `SCB_STRAP_WAIT) begin
        strap_done_reg <= 1'b1;
        addr_lo_reg <= addr_sel_s;
        pll_latched_reg <= pll_strap_s;
      end else begin
        strap_wait_reg <= strap_wait_reg + 2'h1;
      end
    end
  end
  // ==========================================
  // register bank
  reg [7:0] output_enable_ctrl_reg;
  reg [7:0] pll_mode_amplitude_ctrl_reg;
  reg [7:0] output_edge_speed_ctrl_reg;
  reg [7:0] frequency_select_ctrl_reg;
  reg [7:0] stop_ctrl_reg;
  reg [7:0] idx_reg;
  reg [7:0] rd_data;
  always @* begin
    if (idx_reg == `SCB_IDX_OUTPUT_ENABLE) begin
      rd_data = output_enable_ctrl_reg;
    end else if (idx_reg == `SCB_IDX_PLL_MODE) begin
      rd_data = {pll_latched_reg, pll_mode_amplitude_ctrl_reg[5:0]};
    end else if (idx_reg == `SCB_IDX_EDGE_SPEED) begin
      rd_data = output_edge_speed_ctrl_reg;
    end else if (idx_reg == `SCB_IDX_FREQ_SEL) begin
      rd_data = frequency_select_ctrl_reg;
    end else if (idx_reg == `SCB_IDX_RSVD4) begin
      rd_data = `SCB_RST_RSVD4;
    end else if (idx_reg == `SCB_IDX_STOP_CTRL) begin
      rd_data = stop_ctrl_reg;
    end else begin
      rd_data = 8'h00;
    end
  end
  // ==========================================
  // protocol engine
  reg [5:0] state_reg;
  reg [7:0] shift_reg;
  reg [3:0] bit_cnt_reg;
  reg [1:0] phase_reg;
  reg reading_reg;
  reg addr_ok_reg;
  reg count_sent_reg;
  reg sda_oe_reg;
  reg [7:0] tx_reg;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};
  // store strobe on the last bit of each data byte
  wire wr_en = (state_reg == ST_RXB) && scl_rise && (bit_cnt_reg == 4'd7) && (phase_reg == PH_DATA);
  always @(posedge CLOCK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
      shift_reg <= 8'h00;
      bit_cnt_reg <= 4'h0;
      idx_reg <= 8'h00;
      phase_reg <= PH_INDEX;
      reading_reg <= 1'b0;
      addr_ok_reg <= 1'b0;
      count_sent_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      tx_reg <= 8'h00;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR; // repeated start keeps the index
      bit_cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == 4'd7) begin
              addr_ok_reg <= (shift_reg[6:0] == {`SCB_ADDR_HI, addr_lo_reg});
              reading_reg <= sda_s;
              phase_reg <= PH_INDEX;
              count_sent_reg <= 1'b0;
              state_reg <= ST_ACK;
            end
          end
        end
        ST_RXB: begin
          if (scl_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == 4'd7) begin
              addr_ok_reg <= 1'b1;
              state_reg <= ST_ACK; // every byte acked
              if (phase_reg == PH_INDEX) begin
                idx_reg <= rx_byte;
                phase_reg <= PH_COUNT;
              end else if (phase_reg == PH_COUNT) begin
                phase_reg <= PH_DATA; // count only frames the data; stop ends it
              end else begin
                idx_reg <= idx_reg + 8'd1;
              end
            end
          end
        end
        ST_ACK: begin
          // ack driven from first scl fall to next scl fall
          if (scl_fall) begin
            if (!sda_oe_reg) begin
              if (addr_ok_reg) begin
                sda_oe_reg <= 1'b1;
              end else begin
                state_reg <= ST_IDLE;
              end
            end else begin
              bit_cnt_reg <= 4'h0;
              if (reading_reg) begin
                tx_reg <= count_sent_reg ? rd_data : 8'h01; // count byte first
                count_sent_reg <= 1'b1;
                sda_oe_reg <= count_sent_reg ? ~rd_data[7] : 1'b1;
                state_reg <= ST_TXB;
              end else begin
                sda_oe_reg <= 1'b0;
                state_reg <= ST_RXB;
              end
            end
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
            if (bit_cnt_reg == 4'd7) begin
              sda_oe_reg <= 1'b0;
              state_reg <= ST_MACK;
            end else begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              sda_oe_reg <= ~tx_reg[6];
            end
          end
        end
        ST_MACK: begin
          // index moves at the rise, next byte goes out from the fall, so data only moves with the clock low
          if (scl_rise) begin
            if (sda_s) begin
              state_reg <= ST_IDLE; // host nack ends the read
            end else begin
              idx_reg <= (phase_reg == PH_DATA) ? idx_reg + 8'd1 : idx_reg;
              phase_reg <= PH_DATA;
            end
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            tx_reg <= rd_data;
            sda_oe_reg <= ~rd_data[7];
            state_reg <= ST_TXB;
          end
        end
        default: begin
          sda_oe_reg <= 1'b0;
        end
      endcase
    end
  end
  assign SDA_OUT = 1'b0;
  assign SDA_OE = sda_oe_reg;
  // ==========================================
  // register writes, each byte kept as it completes
  always @(posedge CLOCK) begin
    if (SRST) begin
      output_enable_ctrl_reg <= `SCB_RST_OUTPUT_ENABLE;
      pll_mode_amplitude_ctrl_reg <= `SCB_RST_PLL_MODE;
      output_edge_speed_ctrl_reg <= `SCB_RST_EDGE_SPEED;
      frequency_select_ctrl_reg <= `SCB_RST_FREQ_SEL;
      stop_ctrl_reg <= `SCB_RST_STOP_CTRL;
    end else if (wr_en) begin
      if (idx_reg == `SCB_IDX_OUTPUT_ENABLE) begin
        output_enable_ctrl_reg <= (output_enable_ctrl_reg & ~`SCB_WMASK_OUTPUT_ENABLE) |
          (rx_byte & `SCB_WMASK_OUTPUT_ENABLE);
      end else if (idx_reg == `SCB_IDX_PLL_MODE) begin
        pll_mode_amplitude_ctrl_reg <= (pll_mode_amplitude_ctrl_reg & ~`SCB_WMASK_PLL_MODE) |
          (rx_byte & `SCB_WMASK_PLL_MODE);
      end else if (idx_reg == `SCB_IDX_EDGE_SPEED) begin
        output_edge_speed_ctrl_reg <= (output_edge_speed_ctrl_reg & ~`SCB_WMASK_EDGE_SPEED) |
          (rx_byte & `SCB_WMASK_EDGE_SPEED);
      end else if (idx_reg == `SCB_IDX_FREQ_SEL) begin
        frequency_select_ctrl_reg <= (frequency_select_ctrl_reg & ~`SCB_WMASK_FREQ_SEL) |
          (rx_byte & `SCB_WMASK_FREQ_SEL);
      end else if (idx_reg == `SCB_IDX_STOP_CTRL) begin
        stop_ctrl_reg <= (stop_ctrl_reg & ~`SCB_WMASK_STOP_CTRL) | (rx_byte & `SCB_WMASK_STOP_CTRL);
      end
    end
  end
  // ==========================================
  // control outputs, registered
  always @(posedge CLOCK) begin
    if (SRST) begin
      FIRST_OUTPUT_ACTIVE <= 1'b0;
      SECOND_OUTPUT_ACTIVE <= 1'b0;
      DISABLE_STATE <= 2'b00;
      PLL_MODE <= 2'b00;
      AMPLITUDE <= 2'b10;
      FIRST_OUTPUT_EDGE_SPEED <= 1'b1;
      SECOND_OUTPUT_EDGE_SPEED <= 1'b1;
      FEEDBACK_EDGE_SPEED <= 1'b1;
      FREQ_SW_ENABLE <= 1'b0;
      FREQUENCY_CODE <= 2'b00;
    end else begin
      // enable pins are active high here; a cleared bit forces disable
      FIRST_OUTPUT_ACTIVE <= output_enable_ctrl_reg[`SCB_BIT_FIRST_OE] & oe1_s;
      SECOND_OUTPUT_ACTIVE <= output_enable_ctrl_reg[`SCB_BIT_SECOND_OE] & oe2_s;
      DISABLE_STATE <= stop_ctrl_reg[1:0];
      PLL_MODE <= pll_mode_amplitude_ctrl_reg[`SCB_BIT_PLL_SW_EN] ?
        pll_mode_amplitude_ctrl_reg[4:3] : pll_latched_reg;
      AMPLITUDE <= pll_mode_amplitude_ctrl_reg[1:0];
      FIRST_OUTPUT_EDGE_SPEED <= output_edge_speed_ctrl_reg[3];
      SECOND_OUTPUT_EDGE_SPEED <= output_edge_speed_ctrl_reg[4];
      FEEDBACK_EDGE_SPEED <= frequency_select_ctrl_reg[`SCB_BIT_FB_SPEED];
      FREQ_SW_ENABLE <= frequency_select_ctrl_reg[`SCB_BIT_FREQ_SW_EN];
      FREQUENCY_CODE <= frequency_select_ctrl_reg[`SCB_BIT_FREQ_SW_EN] ?
        frequency_select_ctrl_reg[4:3] : 2'b00;
    end
  end
endmodule // scb_config_port

/* File: design/scb_defines.vh */
// constants of the clock buffer configuration port
// Summary of operation
// - slave only, block read and write transfers
// - stop after any byte keeps completed bytes
// - address 1101 plus latched select pin bits
// - write: index, count, data; all acked
// - read: index, restart, count then data
// - byte0 bits4:3 enable outputs while their pins are high, else disable
// - byte1 bits7:6 report latched pll mode
// - byte1 bit5 picks software pll mode
// - software pll bits stored, inert until enabled
// - byte2 bits4:3 output edge speed, fast
// - byte3 bit5 gates frequency select bits
// - byte3 bit0 feedback edge speed, fast
// - byte11 bits1:0 disabled pair levels
`ifndef SCB_DEFINES_VH
`define SCB_DEFINES_VH
// ==========================================
// address
`define SCB_ADDR_HI 4'hd
// ==========================================
// byte indexes
`define SCB_IDX_OUTPUT_ENABLE 8'h00
`define SCB_IDX_PLL_MODE 8'h01
`define SCB_IDX_EDGE_SPEED 8'h02
`define SCB_IDX_FREQ_SEL 8'h03
`define SCB_IDX_RSVD4 8'h04
`define SCB_IDX_STOP_CTRL 8'h0b
// ==========================================
// reset values
`define SCB_RST_OUTPUT_ENABLE 8'h18
`define SCB_RST_PLL_MODE 8'h06
`define SCB_RST_EDGE_SPEED 8'hff
`define SCB_RST_FREQ_SEL 8'hc7
`define SCB_RST_RSVD4 8'hff
`define SCB_RST_STOP_CTRL 8'h40
// ==========================================
// field positions
`define SCB_BIT_SECOND_OE 4
`define SCB_BIT_FIRST_OE 3
`define SCB_BIT_PLL_SW_EN 5
`define SCB_BIT_FREQ_SW_EN 5
`define SCB_BIT_FB_SPEED 0
// ==========================================
// writable masks
`define SCB_WMASK_OUTPUT_ENABLE 8'h18
`define SCB_WMASK_PLL_MODE 8'h3b
`define SCB_WMASK_EDGE_SPEED 8'h18
`define SCB_WMASK_FREQ_SEL 8'h39
`define SCB_WMASK_STOP_CTRL 8'hc3
// ==========================================
// timing: edges after reset release before straps are latched
`define SCB_STRAP_WAIT 2'h2
`endif

/* File: design/scb_sync.v */
// two flop synchroniser for one pin
module scb_sync (
  input wire CLOCK,
  input wire SRST,
  input wire d,
  output wire q
);
  reg s1_reg;
  reg s2_reg;
  always @(posedge CLOCK) begin
    if (SRST) begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end
  assign q = s2_reg;
endmodule // scb_sync

/* File: test/scb_config_port_props.sv */
// assertions on the ports of the clock buffer configuration port
module scb_config_port_props (
  input wire CLOCK,
  input wire SRST,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SDA_OUT,
  input wire SDA_OE,
  input wire [2:0] ADDRESS_SELECT_PIN,
  input wire [1:0] PLL_MODE_STRAP,
  input wire FIRST_OUTPUT_ENABLE_PIN,
  input wire SECOND_OUTPUT_ENABLE_PIN,
  input wire FIRST_OUTPUT_ACTIVE,
  input wire SECOND_OUTPUT_ACTIVE,
  input wire [1:0] DISABLE_STATE,
  input wire [1:0] PLL_MODE,
  input wire [1:0] AMPLITUDE,
  input wire FIRST_OUTPUT_EDGE_SPEED,
  input wire SECOND_OUTPUT_EDGE_SPEED,
  input wire FEEDBACK_EDGE_SPEED,
  input wire FREQ_SW_ENABLE,
  input wire [1:0] FREQUENCY_CODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SRST);
  // ====
  // open drain: only ever pulls low
  a_data_only_low: assert property (SDA_OUT == 1'b0)
    else $error("data line driven high");
  a_reset_out_values: assert property ($fell(SRST) |-> AMPLITUDE == 2'b10 && PLL_MODE == 2'b00
    && FEEDBACK_EDGE_SPEED && FIRST_OUTPUT_EDGE_SPEED && !FIRST_OUTPUT_ACTIVE) else $error("bad values after reset");
  // data may only move while the serial clock is low
  a_data_on_low: assert property ($changed(SDA_OE) |-> !SCL_IN && !$past(SCL_IN, 2))
    else $error("data line moved while clock high");
  a_first_pin_off: assert property (!FIRST_OUTPUT_ENABLE_PIN [*5] |=> !FIRST_OUTPUT_ACTIVE)
    else $error("first output active with pin low");
  a_second_pin_off: assert property (!SECOND_OUTPUT_ENABLE_PIN [*5] |=> !SECOND_OUTPUT_ACTIVE)
    else $error("second output active with pin low");
  a_freq_code_gated: assert property (!FREQ_SW_ENABLE |-> FREQUENCY_CODE == 2'b00)
    else $error("frequency code set while disabled");
  a_amp_on_high: assert property ($changed(AMPLITUDE) |-> SCL_IN && $past(SCL_IN, 2))
    else $error("amplitude changed outside a data byte");
  a_disable_on_high: assert property ($changed(DISABLE_STATE) |-> SCL_IN && $past(SCL_IN, 2))
    else $error("disable state changed outside a data byte");
endmodule // scb_config_port_props

bind scb_config_port scb_config_port_props i_scb_config_port_props (.CLOCK(CLOCK), .SRST(SRST), .SCL_IN(SCL_IN),
  .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .ADDRESS_SELECT_PIN(ADDRESS_SELECT_PIN),
  .PLL_MODE_STRAP(PLL_MODE_STRAP), .FIRST_OUTPUT_ENABLE_PIN(FIRST_OUTPUT_ENABLE_PIN),
  .SECOND_OUTPUT_ENABLE_PIN(SECOND_OUTPUT_ENABLE_PIN), .FIRST_OUTPUT_ACTIVE(FIRST_OUTPUT_ACTIVE),
  .SECOND_OUTPUT_ACTIVE(SECOND_OUTPUT_ACTIVE), .DISABLE_STATE(DISABLE_STATE), .PLL_MODE(PLL_MODE),
  .AMPLITUDE(AMPLITUDE), .FIRST_OUTPUT_EDGE_SPEED(FIRST_OUTPUT_EDGE_SPEED),
  .SECOND_OUTPUT_EDGE_SPEED(SECOND_OUTPUT_EDGE_SPEED), .FEEDBACK_EDGE_SPEED(FEEDBACK_EDGE_SPEED),
  .FREQ_SW_ENABLE(FREQ_SW_ENABLE), .FREQUENCY_CODE(FREQUENCY_CODE));

/* File: test/scb_host.sv */
// serial bus host model issuing block transfers
module scb_host (
  input wire logic clk,
  output logic scl = 1'b1,
  output logic sda_pull = 1'b0,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;
  // ====
  // lines move on falling bench clock edges only; 6+6+6+7 cycles make the 125 ns bit
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one clock pulse, line sampled mid-high
  task automatic pulse(output logic s);
    gap(6);
    scl = 1'b1;
    gap(6);
    s = sda;
    gap(6);
    scl = 1'b0;
    gap(7);
  endtask
  task automatic start;
    sda_pull = 1'b1;
    gap(6);
    scl = 1'b0;
    gap(6);
  endtask
  task automatic rstart;
    sda_pull = 1'b0;
    gap(6);
    scl = 1'b1;
    gap(6);
    start();
  endtask
  // stop only ever follows a whole byte
  task automatic stop;
    sda_pull = 1'b1;
    gap(6);
    scl = 1'b1;
    gap(6);
    sda_pull = 1'b0;
    gap(6);
  endtask
  task automatic put(input logic [7:0] d, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      sda_pull = !d[i];
      pulse(s);
    end
    sda_pull = 1'b0;
    pulse(s);
    acked = !s;
  endtask
  // host acks every byte but the last
  task automatic get(input logic nack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) pulse(d[i]);
    sda_pull = !nack;
    pulse(s);
    sda_pull = 1'b0;
  endtask
endmodule // scb_host

/* File: test/tb_scb_config_port.sv */
// self-checking bench of the clock buffer configuration port
`include "scb_defines.vh"
module tb_scb_config_port;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] ADR = {`SCB_ADDR_HI, 3'h5};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic pin0 = 1'b1;
  logic pin1 = 1'b1;
  logic [2:0] sel = 3'h5;
  logic a;
  logic [7:0] d;
  logic [0:7][7:0] q;
  int error_cnt = 0;
  int checked = 0;
  wire scl, pull, oe, act0, act1, fb, sp0, sp1, fen;
  wire [1:0] dis, pll, amp, fcode;
  wire sda = !(pull || oe);
  always #2.5 clk = ~clk;
  scb_config_port i_scb_config_port (.CLOCK(clk), .SRST(rst), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(oe),
    .ADDRESS_SELECT_PIN(sel), .PLL_MODE_STRAP(2'b10), .FIRST_OUTPUT_ENABLE_PIN(pin0),
    .SECOND_OUTPUT_ENABLE_PIN(pin1), .FIRST_OUTPUT_ACTIVE(act0), .SECOND_OUTPUT_ACTIVE(act1), .DISABLE_STATE(dis),
    .PLL_MODE(pll), .AMPLITUDE(amp), .FIRST_OUTPUT_EDGE_SPEED(sp0), .SECOND_OUTPUT_EDGE_SPEED(sp1),
    .FEEDBACK_EDGE_SPEED(fb), .FREQ_SW_ENABLE(fen), .FREQUENCY_CODE(fcode));
  scb_host i_scb_host (.clk(clk), .scl(scl), .sda_pull(pull), .sda(sda));
  // ====
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tx(input logic [7:0] b);
    i_scb_host.put(b, a);
    chk({7'h00, a}, 8'h01);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] cnt, input int n);
    i_scb_host.start();
    tx({ADR, 1'b0});
    tx(idx);
    tx(cnt);
    for (int i = 0; i < n; i++) tx(q[i]);
    i_scb_host.stop();
  endtask
  task automatic rd(input logic [7:0] idx, input int n);
    i_scb_host.start();
    tx({ADR, 1'b0});
    tx(idx);
    i_scb_host.rstart();
    tx({ADR, 1'b1});
    i_scb_host.get(1'b0, d);
    chk(d, 8'h01);
    for (int i = 0; i < n; i++) begin
      i_scb_host.get(i == n - 1, d);
      chk(d, q[i]);
    end
    i_scb_host.stop();
  endtask
  // ====
  task automatic t_power_up;
    q = {8'h18, 8'h86, 8'hff, 8'hc7, 8'hff, 24'h0};
    rd(8'h00, 5);
    chk({amp, pll, fb, sp0, sp1, fen}, 8'hae);
    chk({6'h00, act1, act0}, 8'h03);
    pin0 = 1'b0;
    repeat (6) @(negedge clk);
    chk({6'h00, act1, act0}, 8'h02);
    pin0 = 1'b1;
    pin1 = 1'b0;
    repeat (6) @(negedge clk);
    chk({6'h00, act1, act0}, 8'h01);
    pin1 = 1'b1;
  endtask
  // reserved byte four swallows the write
  task automatic t_write_all;
    q = {8'hff, 8'h00, 8'hfe, 8'h00, 32'h0};
    wr(8'h01, 8'h04, 4);
    chk({amp, pll, fb, sp0, sp1, fen}, 8'hf1);
    chk({6'h00, fcode}, 8'h03);
    q = {8'hbf, 8'he7, 8'hfe, 8'hff, 32'h0};
    rd(8'h01, 4);
    q[0] = 8'h18;
    wr(8'h01, 8'h01, 1);
    chk({amp, pll, fb, sp0, sp1, fen}, 8'h21);
    q[0] = 8'h19;
    wr(8'h03, 8'h01, 1);
    chk({6'h00, fcode}, 8'h00);
    chk({amp, pll, fb, sp0, sp1, fen}, 8'h28);
  endtask
  // count says two, host stops after one
  task automatic t_early_stop;
    q[0] = 8'h00;
    wr(8'h00, 8'h02, 1);
    chk({6'h00, act1, act0}, 8'h00);
    q = {8'h00, 8'h9c, 48'h0};
    rd(8'h00, 2);
  endtask
  task automatic t_stop_ctrl;
    // the select level latched after reset must outlive a pin change
    sel = 3'h2;
    for (int c = 3; c >= 0; c--) begin
      q[0] = c[7:0];
      wr(8'h0b, 8'h01, 1);
      chk({6'h00, dis}, c[7:0]);
    end
    i_scb_host.start();
    i_scb_host.put({`SCB_ADDR_HI, 3'h4, 1'b0}, a);
    chk({7'h00, a}, 8'h00);
    i_scb_host.stop();
  endtask
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    t_power_up();
    t_write_all();
    t_early_stop();
    t_stop_ctrl();
    give_verdict();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule // tb_scb_config_port
